// >>> felc_consts.svh
// constants of the 100 Mb/s 4b5b line codec
`ifndef FELC_CONSTS_SVH
`define FELC_CONSTS_SVH
// data groups, nibble 15 first, nibble 0 in the low bits
`define FELC_DATA_CODES {5'h1D, 5'h1C, 5'h1B, 5'h1A, 5'h17, 5'h16, 5'h13, 5'h12, \
                         5'h0F, 5'h0E, 5'h0B, 5'h0A, 5'h15, 5'h14, 5'h09, 5'h1E}
`define FELC_CG_I        5'h1F
`define FELC_CG_J        5'h18
`define FELC_CG_K        5'h11
`define FELC_CG_T        5'h0D
`define FELC_CG_R        5'h07
`define FELC_CG_H        5'h04
`define FELC_SSD_NIBBLE  4'h5
`define FELC_BAD_NIBBLE  4'hE
`define FELC_LAST_BIT    3'h4
`define FELC_SEED_WAIT   2'h3
`define FELC_LFSR_RESET  11'h7FF
`define FELC_FIFO_DEPTH  16
`define FELC_FIFO_WIDTH  6
`endif

// >>> felc_pkg.sv
// types of the 100 Mb/s 4b5b line codec
package felc_pkg;
  typedef enum logic [2:0] {
    FELC_TX_IDLE,
    FELC_TX_K,
    FELC_TX_DATA,
    FELC_TX_R
  } felc_tx_state_t;
  typedef enum logic [2:0] {
    FELC_RX_IDLE,
    FELC_RX_J,
    FELC_RX_DATA,
    FELC_RX_T,
    FELC_RX_ESD,
    FELC_RX_BAD
  } felc_rx_state_t;
  typedef logic [4:0] felc_code_t;
endpackage

// >>> felc_line_codec.sv
// 4b5b transmit encoder with scrambler, NRZI and MLT-3, receive group interpreter
`timescale 1ns/1ns
`default_nettype none
`include "felc_consts.svh"
module felc_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             srst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0]    cnt_q, cnt_d;
  logic             push, pop;
  assign in_ready  = (cnt_q != CW'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_comb begin
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule
module felc_line_codec (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              srst,
  // address strap from pins
  input  wire logic [4:0]        phy_addr,
  // transmit nibbles from the MAC
  input  wire logic              tx_en,
  input  wire logic              tx_er,
  input  wire logic              tx_valid,
  input  wire logic [3:0]        txd,
  output logic                   tx_ready,
  // line side transmit levels and the unscrambled code bit
  output logic                   mlt_pos,
  output logic                   mlt_neg,
  output logic                   tx_code_bit,
  // aligned receive code groups
  input  wire logic              rx_code_valid,
  input  wire felc_pkg::felc_code_t rx_code,
  // receive nibbles to the MAC
  output logic [3:0]             rxd,
  output logic                   rx_dv,
  output logic                   rx_er,
  output logic                   crs,
  output logic                   rx_nib_strobe
);
  import felc_pkg::*;
  localparam logic [79:0] DATA_CODES = `FELC_DATA_CODES;
  function automatic felc_code_t enc(input logic [3:0] nib);
    enc = DATA_CODES[5*nib +: 5];
  endfunction
  // {valid, nibble}; valid only for the sixteen data groups
  function automatic logic [4:0] dec(input felc_code_t cg);
    dec = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (DATA_CODES[5*i +: 5] == cg) begin
        dec = {1'b1, 4'(i)};
      end
    end
  endfunction
  // ---------------- strap sync and seed ----------------
  logic [4:0]  addr_m_q, addr_s_q;
  logic [1:0]  seed_cnt_q, seed_cnt_d;
  always_comb begin
    seed_cnt_d = (seed_cnt_q == `FELC_SEED_WAIT) ? seed_cnt_q : seed_cnt_q + 1'b1;
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      addr_m_q   <= '0;
      addr_s_q   <= '0;
      seed_cnt_q <= '0;
    end else begin
      addr_m_q   <= phy_addr;
      addr_s_q   <= addr_m_q;
      seed_cnt_q <= seed_cnt_d;
    end
  end
  // ---------------- MAC side into the FIFO ----------------
  logic       tx_en_q, tx_en_d, eof_pend_q, eof_pend_d;
  logic       f_in_valid, f_in_ready, f_out_valid, f_pop;
  logic [5:0] f_in_data, f_out_data;
  // entry: {end marker, error, nibble}
  always_comb begin
    tx_en_d    = tx_en;
    tx_ready   = f_in_ready && !eof_pend_q;
    f_in_valid = eof_pend_q || (tx_en && tx_valid);
    f_in_data  = eof_pend_q ? 6'h20 : {1'b0, tx_er, txd};
    eof_pend_d = eof_pend_q;
    if (eof_pend_q && f_in_ready) begin
      eof_pend_d = 1'b0;
    end
    if (tx_en_q && !tx_en) begin
      eof_pend_d = 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      tx_en_q    <= 1'b0;
      eof_pend_q <= 1'b0;
    end else begin
      tx_en_q    <= tx_en_d;
      eof_pend_q <= eof_pend_d;
    end
  end
  felc_fifo #(
    .WIDTH (`FELC_FIFO_WIDTH),
    .DEPTH (`FELC_FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .srst      (srst),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_pop),
    .out_data  (f_out_data)
  );
  // ---------------- group encoder and serializer ----------------
  felc_tx_state_t tx_st_q, tx_st_d;
  felc_code_t     shift_q, shift_d, grp;
  logic [2:0]     bit_q, bit_d;
  logic [10:0]    lfsr_q, lfsr_d;
  logic           scr, nrzi_q, nrzi_d, tbit_q, tbit_d;
  logic [1:0]     ph_q, ph_d;
  logic           last;
  always_comb begin
    last    = (bit_q == `FELC_LAST_BIT);
    tx_st_d = tx_st_q;
    grp     = `FELC_CG_I;
    f_pop   = 1'b0;
    case (tx_st_q)
      FELC_TX_IDLE: begin
        if (f_out_valid) begin
          f_pop = last;
          if (!f_out_data[5]) begin
            grp     = `FELC_CG_J;
            tx_st_d = FELC_TX_K;
          end
        end
      end
      FELC_TX_K: begin
        grp     = `FELC_CG_K;
        f_pop   = last && f_out_valid && !f_out_data[5];
        tx_st_d = FELC_TX_DATA;
      end
      FELC_TX_DATA: begin
        if (!f_out_valid) begin
          grp = `FELC_CG_H;
        end else if (f_out_data[5]) begin
          grp     = `FELC_CG_T;
          f_pop   = last;
          tx_st_d = FELC_TX_R;
        end else begin
          grp   = f_out_data[4] ? `FELC_CG_H : enc(f_out_data[3:0]);
          f_pop = last;
        end
      end
      FELC_TX_R: begin
        grp     = `FELC_CG_R;
        tx_st_d = FELC_TX_IDLE;
      end
      default: begin
        tx_st_d = FELC_TX_IDLE;
      end
    endcase
    if (!last) begin
      tx_st_d = tx_st_q;
    end
    bit_d   = last ? 3'h0 : bit_q + 1'b1;
    shift_d = last ? grp : {shift_q[3:0], 1'b0};
    // x^11 + x^9 + 1 stream cipher, seed from the strap
    scr     = shift_q[4] ^ lfsr_q[10] ^ lfsr_q[8];
    lfsr_d  = {lfsr_q[9:0], lfsr_q[10] ^ lfsr_q[8]};
    if (seed_cnt_q != `FELC_SEED_WAIT) begin
      lfsr_d = {1'b1, addr_s_q, addr_s_q};
    end
    nrzi_d = nrzi_q ^ scr;
    tbit_d = shift_q[4];
    ph_d   = nrzi_d ? ph_q + 1'b1 : ph_q;
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      tx_st_q <= FELC_TX_IDLE;
      shift_q <= `FELC_CG_I;
      bit_q   <= '0;
      lfsr_q  <= `FELC_LFSR_RESET;
      nrzi_q  <= 1'b0;
      tbit_q  <= 1'b0;
      ph_q    <= '0;
    end else begin
      tx_st_q <= tx_st_d;
      shift_q <= shift_d;
      bit_q   <= bit_d;
      lfsr_q  <= lfsr_d;
      nrzi_q  <= nrzi_d;
      tbit_q  <= tbit_d;
      ph_q    <= ph_d;
    end
  end
  // levels cycle 0, +, 0, -
  assign mlt_pos     = (ph_q == 2'h1);
  assign mlt_neg     = (ph_q == 2'h3);
  assign tx_code_bit = tbit_q;
  // ---------------- receive group interpreter ----------------
  felc_rx_state_t rx_st_q, rx_st_d;
  logic [3:0] rxd_q, rxd_d;
  logic       dv_q, dv_d, er_q, er_d, crs_q, crs_d, stb_q, stb_d, idl_q, idl_d;
  logic [4:0] dn;
  logic       is_i;
  always_comb begin
    dn      = dec(rx_code);
    is_i    = (rx_code == `FELC_CG_I);
    rx_st_d = rx_st_q;
    rxd_d   = rxd_q;
    dv_d    = dv_q;
    er_d    = er_q;
    crs_d   = crs_q;
    idl_d   = idl_q;
    stb_d   = rx_code_valid;
    if (rx_code_valid) begin
      er_d = 1'b0;
      case (rx_st_q)
        FELC_RX_IDLE: begin
          dv_d  = 1'b0;
          crs_d = 1'b0;
          if (rx_code == `FELC_CG_J) begin
            rxd_d   = `FELC_SSD_NIBBLE;
            crs_d   = 1'b1;
            rx_st_d = FELC_RX_J;
          end else if (!is_i) begin
            er_d    = 1'b1;
            rxd_d   = `FELC_BAD_NIBBLE;
            crs_d   = 1'b1;
            idl_d   = 1'b0;
            rx_st_d = FELC_RX_BAD;
          end
        end
        FELC_RX_J: begin
          if (rx_code == `FELC_CG_K) begin
            rxd_d   = `FELC_SSD_NIBBLE;
            dv_d    = 1'b1;
            rx_st_d = FELC_RX_DATA;
          end else begin
            er_d    = 1'b1;
            rxd_d   = `FELC_BAD_NIBBLE;
            idl_d   = is_i;
            rx_st_d = FELC_RX_BAD;
          end
        end
        FELC_RX_DATA: begin
          if (rx_code == `FELC_CG_T) begin
            rx_st_d = FELC_RX_T;
          end else if (dn[4]) begin
            rxd_d = dn[3:0];
          end else begin
            er_d = 1'b1;
          end
        end
        FELC_RX_T: begin
          if (rx_code == `FELC_CG_R) begin
            crs_d   = 1'b0;
            dv_d    = 1'b0;
            rx_st_d = FELC_RX_ESD;
          end else begin
            er_d    = 1'b1;
            idl_d   = is_i;
            rx_st_d = FELC_RX_BAD;
          end
        end
        FELC_RX_ESD: begin
          if (is_i) begin
            rx_st_d = FELC_RX_IDLE;
          end else begin
            er_d    = 1'b1;
            rxd_d   = `FELC_BAD_NIBBLE;
            crs_d   = 1'b1;
            idl_d   = 1'b0;
            rx_st_d = FELC_RX_BAD;
          end
        end
        FELC_RX_BAD: begin
          dv_d  = 1'b0;
          idl_d = is_i;
          if (is_i && idl_q) begin
            crs_d   = 1'b0;
            rx_st_d = FELC_RX_IDLE;
          end else begin
            er_d  = 1'b1;
            rxd_d = `FELC_BAD_NIBBLE;
          end
        end
        default: begin
          rx_st_d = FELC_RX_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      rx_st_q <= FELC_RX_IDLE;
      rxd_q   <= '0;
      dv_q    <= 1'b0;
      er_q    <= 1'b0;
      crs_q   <= 1'b0;
      stb_q   <= 1'b0;
      idl_q   <= 1'b0;
    end else begin
      rx_st_q <= rx_st_d;
      rxd_q   <= rxd_d;
      dv_q    <= dv_d;
      er_q    <= er_d;
      crs_q   <= crs_d;
      stb_q   <= stb_d;
      idl_q   <= idl_d;
    end
  end
  assign rxd           = rxd_q;
  assign rx_dv         = dv_q;
  assign rx_er         = er_q;
  assign crs           = crs_q;
  assign rx_nib_strobe = stb_q;
endmodule
`default_nettype wire

// >>> felc_line_codec_sva.sv
// assertion checker for the line codec ports
`timescale 1ns/1ns
`default_nettype none
`include "felc_consts.svh"
module felc_line_codec_sva (
  // clock and reset
  input wire logic                 clock,
  input wire logic                 srst,
  // line levels
  input wire logic                 mlt_pos,
  input wire logic                 mlt_neg,
  // receive side
  input wire logic                 rx_code_valid,
  input wire felc_pkg::felc_code_t rx_code,
  input wire logic [3:0]           rxd,
  input wire logic                 rx_dv,
  input wire logic                 rx_er,
  input wire logic                 crs
);
  import felc_pkg::*;
  felc_code_t last_q, last_d, prev_q, prev_d;
  // last two accepted groups, idle after reset
  always_comb begin
    last_d = last_q;
    prev_d = prev_q;
    if (srst) begin
      last_d = `FELC_CG_I;
      prev_d = `FELC_CG_I;
    end else if (rx_code_valid) begin
      last_d = rx_code;
      prev_d = last_q;
    end
  end
  always_ff @(posedge clock) begin
    last_q <= last_d;
    prev_q <= prev_d;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  property p_mlt_three; !(mlt_pos && mlt_neg); endproperty
  a_mlt_three: assert property (p_mlt_three) else $error("both line levels high");
  property p_mlt_step; mlt_pos |=> !mlt_neg; endproperty
  a_mlt_step: assert property (p_mlt_step) else $error("line jumped past zero");
  property p_mlt_back; mlt_neg |=> !mlt_pos; endproperty
  a_mlt_back: assert property (p_mlt_back) else $error("line jumped from minus to plus");
  property p_j_ok;
    rx_code_valid && rx_code == `FELC_CG_J && last_q == `FELC_CG_I && prev_q == `FELC_CG_I
      |=> rxd == 4'h5 && crs && !rx_er;
  endproperty
  a_j_ok: assert property (p_j_ok) else $error("start group after idle not taken");
  property p_j_bad; rx_code_valid && rx_code == `FELC_CG_J && last_q != `FELC_CG_I |=> rx_er;
  endproperty
  a_j_bad: assert property (p_j_bad) else $error("stray J without error");
  property p_k_bad; rx_code_valid && rx_code == `FELC_CG_K && last_q != `FELC_CG_J |=> rx_er;
  endproperty
  a_k_bad: assert property (p_k_bad) else $error("stray K without error");
  property p_t_bad;
    rx_code_valid && last_q == `FELC_CG_T && rx_code != `FELC_CG_R && rx_dv |=> rx_er;
  endproperty
  a_t_bad: assert property (p_t_bad) else $error("T without R not flagged");
  property p_r_ok;
    rx_code_valid && rx_code == `FELC_CG_R && last_q == `FELC_CG_T && rx_dv |=> !crs && !rx_dv;
  endproperty
  a_r_ok: assert property (p_r_ok) else $error("end pair kept carrier");
  property p_r_bad; rx_code_valid && rx_code == `FELC_CG_R && last_q != `FELC_CG_T |=> rx_er;
  endproperty
  a_r_bad: assert property (p_r_bad) else $error("stray R without error");
  property p_invalid; rx_code_valid && rx_dv && rx_code inside {5'h00, 5'h01, 5'h02} |=> rx_er;
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid group not flagged");
  property p_ctrl;
    rx_code_valid && rx_dv && rx_code inside {`FELC_CG_I, `FELC_CG_J, `FELC_CG_K} |=> rx_er;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control group in data not flagged");
  c_frame_end: cover property (rx_code_valid && rx_code == `FELC_CG_R && last_q == `FELC_CG_T);
  c_error: cover property ($rose(rx_er));
  c_neg: cover property (mlt_neg);
endmodule
bind felc_line_codec felc_line_codec_sva u_sva (
  .clock(clock), .srst(srst), .mlt_pos(mlt_pos), .mlt_neg(mlt_neg), .rx_code_valid(rx_code_valid),
  .rx_code(rx_code), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .crs(crs));
`default_nettype wire

// >>> felc_mac_model.sv
// nibble source standing in for the MAC
`timescale 1ns/1ns
`default_nettype none
module felc_mac_model (
  // clock
  input wire logic  clock,
  // transmit nibbles
  output logic      tx_en,
  output logic      tx_er,
  output logic      tx_valid,
  output logic [3:0] txd,
  input wire logic  tx_ready
);
  logic [4:0] q[$];
  int         slow;
  initial begin
    tx_en = 1'b0;
    tx_er = 1'b0;
    tx_valid = 1'b0;
    txd = 4'h0;
    slow = 0;
  end
  // sends q as one frame, {error, nibble} per entry
  task automatic send();
    logic [4:0] u;
    @(posedge clock);
    tx_en <= 1'b1;
    while (q.size() > 0) begin
      u = q.pop_front();
      tx_valid <= 1'b1;
      tx_er <= u[4];
      txd <= u[3:0];
      do @(negedge clock); while (tx_ready !== 1'b1);
      @(posedge clock);
      if (slow > 0 || q.size() == 0) begin
        tx_valid <= 1'b0;
        tx_er <= 1'b0;
        txd <= ~u[3:0];
        repeat (slow) @(posedge clock);
      end
    end
    tx_en <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> felc_line_codec_tb_top.sv
// self-checking bench of the line codec
`timescale 1ns/1ns
`default_nettype none
`include "felc_consts.svh"
module felc_line_codec_tb_top;
  import felc_pkg::*;
  localparam logic [79:0] DC = `FELC_DATA_CODES;
  logic       clock, srst, tx_en, tx_er, tx_valid, tx_ready, mlt_pos, mlt_neg, tx_code_bit;
  logic       rx_code_valid, rx_dv, rx_er, crs, rx_nib_strobe;
  logic [4:0] phy_addr, a1, vs[7];
  logic [3:0] txd, rxd, d;
  felc_code_t rx_code;
  logic [63:0] s1, s2;
  int         seed = 92;
  int         error_cnt = 0;
  int         n_tests = 0;
  felc_line_codec uut (.clock(clock), .srst(srst), .phy_addr(phy_addr), .tx_en(tx_en),
    .tx_er(tx_er), .tx_valid(tx_valid), .txd(txd), .tx_ready(tx_ready), .mlt_pos(mlt_pos),
    .mlt_neg(mlt_neg), .tx_code_bit(tx_code_bit), .rx_code_valid(rx_code_valid),
    .rx_code(rx_code), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .crs(crs),
    .rx_nib_strobe(rx_nib_strobe));
  felc_mac_model mac (.clock(clock), .tx_en(tx_en), .tx_er(tx_er), .tx_valid(tx_valid),
    .txd(txd), .tx_ready(tx_ready));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic check(input logic [4:0] seen, input logic [4:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic line_sig(input logic [4:0] a, output logic [63:0] s);
    @(posedge clock);
    phy_addr <= a;
    srst <= 1'b1;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    repeat (10) @(posedge clock);
    repeat (64) begin
      @(negedge clock);
      s = {s[62:0], mlt_pos};
    end
  endtask
  task automatic tx_frame(input int n, input int ei);
    logic [4:0] e[$];
    logic [9:0] sr;
    logic [4:0] g;
    int k;
    sr = '0;
    for (int i = 0; i < n; i++) begin
      d = 4'($random(seed));
      mac.q.push_back({i == ei, d});
      if (i > 1) e.push_back(i == ei ? `FELC_CG_H : DC[d*5 +: 5]);
    end
    e.push_back(`FELC_CG_T);
    e.push_back(`FELC_CG_R);
    repeat (4) e.push_back(`FELC_CG_I);
    fork
      mac.send();
      begin
        k = 0;
        while (sr !== {`FELC_CG_J, `FELC_CG_K} && k < 400) begin
          @(negedge clock);
          sr = {sr[8:0], tx_code_bit};
          k++;
        end
        check(5'(k < 400), 5'h01);
        foreach (e[j]) begin
          repeat (5) begin
            @(negedge clock);
            g = {g[3:0], tx_code_bit};
          end
          check(g, e[j]);
        end
      end
    join
  endtask
  task automatic rx(input logic [4:0] c, input int er, input int cs, input int dv, input int nb);
    @(posedge clock);
    rx_code_valid <= 1'b1;
    rx_code <= c;
    @(posedge clock);
    rx_code_valid <= 1'b0;
    rx_code <= ~c;
    @(negedge clock);
    check(5'(rx_nib_strobe), 5'h01);
    if (er >= 0) check(5'(rx_er), 5'(er));
    if (cs >= 0) check(5'(crs), 5'(cs));
    if (dv >= 0) check(5'(rx_dv), 5'(dv));
    if (nb >= 0) check(5'(rxd), 5'(nb));
  endtask
  task automatic idle2();
    rx(`FELC_CG_I, -1, -1, -1, -1);
    rx(`FELC_CG_I, 0, 0, 0, -1);
  endtask
  task automatic sof();
    rx(`FELC_CG_J, 0, 1, 0, 5);
    rx(`FELC_CG_K, 0, 1, 1, 5);
  endtask
  initial begin
    srst = 1'b1;
    phy_addr = 5'h00;
    rx_code_valid = 1'b0;
    rx_code = 5'h00;
    vs = '{5'h00, 5'h01, 5'h02, `FELC_CG_I, `FELC_CG_J, `FELC_CG_K, `FELC_CG_H};
    a1 = 5'($random(seed));
    line_sig(a1, s1);
    line_sig(a1 ^ 5'h0B, s2);
    check(5'(s1 == s2), 5'h00);
    tx_frame(20, -1);
    mac.slow = 3;
    tx_frame(9, 5);
    idle2();
    sof();
    repeat (4) begin
      d = 4'($random(seed));
      rx(DC[d*5 +: 5], 0, 1, 1, d);
    end
    rx(`FELC_CG_T, 0, 1, 1, d);
    rx(`FELC_CG_R, 0, 0, 0, -1);
    idle2();
    sof();
    foreach (vs[i]) begin
      rx(DC[4:0], 0, 1, 1, 0);
      rx(vs[i], 1, 1, 1, 0);
    end
    rx(`FELC_CG_T, 0, 1, 1, 0);
    rx(`FELC_CG_R, 0, 0, 0, -1);
    idle2();
    sof();
    rx(`FELC_CG_T, 0, 1, 1, 5);
    rx(DC[4:0], 1, 1, -1, -1);
    idle2();
    foreach (vs[i]) if (i > 3) begin
      rx(i == 4 ? `FELC_CG_K : i == 5 ? `FELC_CG_R : `FELC_CG_T, 1, 1, -1, 14);
      idle2();
    end
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    complete_run();
  end
endmodule
`default_nettype wire
